// [inc/latch_pkg.sv]
package latch_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int IDX_W = 3;
    localparam int ADDR_W_DEF = 8;
    localparam int COUNT_W_DEF = 24;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [IDX_W-1:0] REG_COUNT_IDX = 3'h0;
    localparam logic [IDX_W-1:0] REG_LATCH_IDX = 3'h1;
    localparam logic [IDX_W-1:0] REG_MASK_IDX = 3'h2;
    localparam logic [IDX_W-1:0] REG_CTRL_IDX = 3'h6;
    localparam logic [IDX_W-1:0] REG_STAT_IDX = 3'h7;

    // ------------------------------------------------------------
    // Interrupt sources and conditioned inputs
    // ------------------------------------------------------------
    localparam int NUM_SRC = 5;
    localparam int NUM_IN = 6;
    localparam int SRC_TIMER = 0;
    localparam int SRC_LATCH = 1;
    localparam int SRC_STOP = 2;
    localparam int SRC_MARK = 3;
    localparam int SRC_CMP = 4;
    localparam int IN_CLEAR = 5;
    localparam logic [NUM_SRC-1:0] TIMER_ONLY = 5'h01;

    // ------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TIMER_BIT = 0;
    localparam int CTRL_LATCH_POL = 12;
    localparam int CTRL_STOP_POL = 13;
    localparam int CTRL_CLEAR_POL = 14;
    localparam logic [NUM_SRC-1:0] MASK_RST = 5'h00;
    localparam logic [NUM_SRC-1:0] STAT_RST = 5'h00;

    // ------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [inc/reg_bus_if.sv]
`timescale 1ns/1ps
interface reg_bus_if;
    import latch_pkg::*;
    logic wrReq;
    logic wrHit;
    logic [IDX_W-1:0] wrIdx;
    logic [DATA_W-1:0] wrData;
    logic [3:0] wrStrb;
    logic [1:0] wrResp;
    logic rdReq;
    logic rdHit;
    logic [IDX_W-1:0] rdIdx;
    logic [DATA_W-1:0] rdData;

    modport front (
        output wrReq, wrHit, wrIdx, wrData, wrStrb, rdReq, rdHit, rdIdx,
        input wrResp, rdData
    );
    modport core (
        input wrReq, wrHit, wrIdx, wrData, wrStrb, rdReq, rdHit, rdIdx,
        output wrResp, rdData
    );
endinterface

// [core/event_sync.sv]
`timescale 1ns/1ps
module event_sync #(
    parameter int N = 6
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [N-1:0] rawIn,
    input wire logic [N-1:0] activeLow,
    output logic [N-1:0] pulse
);
    // ------------------------------------------------------------
    // Two-stage capture, polarity, edge per input
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            logic meta_r;
            logic sync_r;
            logic lvl_r;
            logic prev_r;
            always_ff @(posedge ref_clk) begin
                if (!rstn) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                    lvl_r <= 1'b0;
                    prev_r <= 1'b0;
                end else if (ce) begin
                    meta_r <= rawIn[i];
                    sync_r <= meta_r;
                    lvl_r <= sync_r ^ activeLow[i];
                    prev_r <= lvl_r;
                end
            end
            // Flipping polarity while idle yields one edge
            assign pulse[i] = lvl_r & ~prev_r;
        end
    endgenerate
endmodule

// [core/axil_front.sv]
`timescale 1ns/1ps
module axil_front
    import latch_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    reg_bus_if.front bus
);
    logic awHeld_r;
    logic wHeld_r;
    logic [ADDR_W-1:0] wAddr_r;
    logic [DATA_W-1:0] wData_r;
    logic [3:0] wStrb_r;

    // ------------------------------------------------------------
    // Handshakes and decode
    // ------------------------------------------------------------
    // No address or write-data handshake completes while the clock enable holds state frozen
    assign awready = ce && !awHeld_r && !bvalid;
    assign wready = ce && !wHeld_r && !bvalid;
    assign arready = ce && !rvalid;
    assign bus.wrReq = awHeld_r && wHeld_r && !bvalid;
    assign bus.wrIdx = wAddr_r[IDX_W+1:2];
    assign bus.wrHit = (wAddr_r[ADDR_W-1:IDX_W+2] == '0);
    assign bus.wrData = wData_r;
    assign bus.wrStrb = wStrb_r;
    assign bus.rdReq = arvalid && arready;
    assign bus.rdIdx = araddr[IDX_W+1:2];
    assign bus.rdHit = (araddr[ADDR_W-1:IDX_W+2] == '0);

    // ------------------------------------------------------------
    // Write path: address and data in either order
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            wAddr_r <= '0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_r <= 1'b1;
                wAddr_r <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_r <= 1'b1;
                wData_r <= wdata;
                wStrb_r <= wstrb;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (bus.wrReq) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= bus.wrHit ? bus.wrResp : RESP_DECERR;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
            if (bus.rdReq) begin
                rvalid <= 1'b1;
                rdata <= bus.rdHit ? bus.rdData : 32'h0000_0000;
                rresp <= bus.rdHit ? RESP_OKAY : RESP_DECERR;
            end
        end
    end
endmodule

// [core/counter_interrupt_latch.sv]
`timescale 1ns/1ps
// Behaviour
// - Five sources may interrupt: timer, latch, stop, marker-origin, compare.
// - Timer interrupt mode excludes every other source, and vice versa.
// - Every event input passes three register stages before use.
// - An event sets its status bit, held until software clears it.
// - While a status bit is set, further events of that source are ignored.
// - Registers zero and one hold counter values and are readable.
// - Writes to registers zero and one get a bus error response.
// - Latch, stop and clear inputs each have a polarity bit in register six.
// - Only register positions zero to seven answer; others are not this module.
module counter_interrupt_latch
    import latch_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int COUNT_W = COUNT_W_DEF
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic timerExpire,
    input wire logic latchIn,
    input wire logic stopIn,
    input wire logic markerIn,
    input wire logic originIn,
    input wire logic compareEq,
    input wire logic clearIn,
    input wire logic [COUNT_W-1:0] countValue,
    input wire logic [COUNT_W-1:0] latchValue,
    output logic irq,
    output logic counterClear
);
    reg_bus_if bus ();

    logic [NUM_SRC-1:0] mask_r;
    logic timerMode_r;
    logic latchPol_r;
    logic stopPol_r;
    logic clearPol_r;
    logic [NUM_SRC-1:0] status_r;
    logic [NUM_SRC-1:0] status_nxt;
    logic irq_r;
    logic counterClear_r;

    logic [NUM_IN-1:0] rawIn;
    logic [NUM_IN-1:0] activeLow;
    logic [NUM_IN-1:0] pulse;
    logic [NUM_SRC-1:0] evPulse;
    logic [NUM_SRC-1:0] arm;
    logic [NUM_SRC-1:0] setMask;
    logic [NUM_SRC-1:0] clrMask;
    logic wrAny;
    logic wrMask;
    logic wrCtrl0;
    logic wrCtrl1;
    logic wrStat;
    logic wrCounter;

    // ------------------------------------------------------------
    // Bus front end
    // ------------------------------------------------------------
    axil_front #(
        .ADDR_W(ADDR_W)
    ) u_front (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .bus(bus.front)
    );

    // ------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------
    assign rawIn[SRC_TIMER] = timerExpire;
    assign rawIn[SRC_LATCH] = latchIn;
    assign rawIn[SRC_STOP] = stopIn;
    assign rawIn[SRC_MARK] = markerIn & originIn;
    assign rawIn[SRC_CMP] = compareEq;
    assign rawIn[IN_CLEAR] = clearIn;

    assign activeLow[SRC_TIMER] = 1'b0;
    assign activeLow[SRC_LATCH] = latchPol_r;
    assign activeLow[SRC_STOP] = stopPol_r;
    assign activeLow[SRC_MARK] = 1'b0;
    assign activeLow[SRC_CMP] = 1'b0;
    assign activeLow[IN_CLEAR] = clearPol_r;

    event_sync #(
        .N(NUM_IN)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .rawIn(rawIn),
        .activeLow(activeLow),
        .pulse(pulse)
    );

    assign evPulse = pulse[NUM_SRC-1:0];

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wrAny = bus.wrReq && bus.wrHit;
    assign wrCounter = wrAny &&
        (bus.wrIdx == REG_COUNT_IDX || bus.wrIdx == REG_LATCH_IDX);
    assign wrMask = wrAny && bus.wrIdx == REG_MASK_IDX && bus.wrStrb[0];
    assign wrCtrl0 = wrAny && bus.wrIdx == REG_CTRL_IDX && bus.wrStrb[0];
    assign wrCtrl1 = wrAny && bus.wrIdx == REG_CTRL_IDX && bus.wrStrb[1];
    assign wrStat = wrAny && bus.wrIdx == REG_STAT_IDX && bus.wrStrb[0];
    assign clrMask = wrStat ? bus.wrData[NUM_SRC-1:0] : '0;

    // Counter registers refuse writes
    assign bus.wrResp = wrCounter ? RESP_SLVERR : RESP_OKAY;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        bus.rdData = 32'h0000_0000;
        case (bus.rdIdx)
            REG_COUNT_IDX: bus.rdData[COUNT_W-1:0] = countValue;
            REG_LATCH_IDX: bus.rdData[COUNT_W-1:0] = latchValue;
            REG_MASK_IDX: bus.rdData[NUM_SRC-1:0] = mask_r;
            REG_CTRL_IDX: begin
                bus.rdData[CTRL_TIMER_BIT] = timerMode_r;
                bus.rdData[CTRL_LATCH_POL] = latchPol_r;
                bus.rdData[CTRL_STOP_POL] = stopPol_r;
                bus.rdData[CTRL_CLEAR_POL] = clearPol_r;
            end
            REG_STAT_IDX: bus.rdData[NUM_SRC-1:0] = status_r;
            default: bus.rdData = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Mask and control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            mask_r <= MASK_RST;
        end else if (ce && wrMask) begin
            mask_r <= bus.wrData[NUM_SRC-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            timerMode_r <= 1'b0;
            latchPol_r <= 1'b0;
            stopPol_r <= 1'b0;
            clearPol_r <= 1'b0;
        end else if (ce) begin
            if (wrCtrl0) begin
                timerMode_r <= bus.wrData[CTRL_TIMER_BIT];
            end
            if (wrCtrl1) begin
                latchPol_r <= bus.wrData[CTRL_LATCH_POL];
                stopPol_r <= bus.wrData[CTRL_STOP_POL];
                clearPol_r <= bus.wrData[CTRL_CLEAR_POL];
            end
        end
    end

    // ------------------------------------------------------------
    // Sticky status with write-one-to-clear
    // ------------------------------------------------------------
    // Timer mode arms only the timer; otherwise every other source
    assign arm = timerMode_r ? TIMER_ONLY : ~TIMER_ONLY;
    assign setMask = evPulse & arm & (~status_r | clrMask);
    // Set wins over a clear in the same cycle
    assign status_nxt = (status_r & ~clrMask) | setMask;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status_r <= STAT_RST;
        end else if (ce) begin
            status_r <= status_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt and counter clear outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(status_nxt & mask_r & arm);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            counterClear_r <= 1'b0;
        end else if (ce) begin
            counterClear_r <= pulse[IN_CLEAR];
        end
    end

    assign irq = irq_r;
    assign counterClear = counterClear_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_status_hold: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && clrMask == '0) |=> ((status_r & $past(status_r)) == $past(status_r))
    ) else $error("status bit dropped without a clear");

    a_timer_exclusive: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && timerMode_r)
            |=> ((status_r & ~$past(status_r) & ~TIMER_ONLY) == '0)
    ) else $error("non-timer status set in timer mode");

    a_timer_off: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && !timerMode_r && !status_r[SRC_TIMER]) |=> !status_r[SRC_TIMER]
    ) else $error("timer status set outside timer mode");

    a_set_has_cause: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ce |=> ((status_r & ~$past(status_r) & ~$past(evPulse)) == '0)
    ) else $error("status set without a conditioned event");

    a_ignore_repeat: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && clrMask == '0 && (evPulse & status_r) != '0
            && (evPulse & arm & ~status_r) == '0) |=> $stable(status_r)
    ) else $error("repeat event changed a set status");

    a_rearm_capture: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        ce |=> ((status_r & $past(evPulse & arm)) == $past(evPulse & arm))
    ) else $error("armed event not captured");

    a_counter_read: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && bus.rdReq && bus.rdHit && bus.rdIdx == REG_COUNT_IDX)
            |=> (rvalid && rresp == RESP_OKAY
                && rdata[COUNT_W-1:0] == $past(countValue))
    ) else $error("counter read answered wrongly");

    a_ro_write_err: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && wrCounter) |=> (bvalid && bresp == RESP_SLVERR)
    ) else $error("counter write not refused");

    a_range_decode: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && bus.wrReq && !bus.wrHit) |=> (bvalid && bresp == RESP_DECERR)
    ) else $error("out of range write not decode error");

    a_pol_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (ce && pulse[IN_CLEAR]) |=> counterClear
    ) else $error("clear input did not reach output");
endmodule

// [test/host_model.sv]
`timescale 1ns/1ps
module host_model
    import latch_pkg::*;
(
    input wire logic ref_clk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [DATA_W-1:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
    end

    // ----------------------------------------
    // Write: address and data offered together
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge ref_clk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!done) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // ----------------------------------------
    // Read: whole word fetched in one transfer
    // ----------------------------------------
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        while (!done) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                {d, r} = {rdata, rresp};
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask
endmodule

// [test/tb_counter_interrupt_latch.sv]
`timescale 1ns/1ps
module tb_counter_interrupt_latch;
    import latch_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic orig = 1'b0;
    logic [5:0] ev = '0;
    logic [23:0] cv = '0;
    logic [23:0] lv = '0;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, counterClear;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    int seenClr = 0;
    int clrCnt = 0;
    int stat = 0;
    int mask = 0;
    int ctrl = 0;
    int pb[6] = '{0, CTRL_LATCH_POL, CTRL_STOP_POL, 0, 0, CTRL_CLEAR_POL};
    int unsigned seed = 62152;

    always #50 ref_clk = ~ref_clk;

    counter_interrupt_latch uut (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .timerExpire(ev[0]), .latchIn(ev[1]), .stopIn(ev[2]),
        .markerIn(ev[3]), .originIn(orig), .compareEq(ev[4]), .clearIn(ev[5]),
        .countValue(cv), .latchValue(lv), .irq(irq), .counterClear(counterClear));

    host_model host (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    always @(posedge ref_clk) begin
        cycles++;
        if (counterClear === 1'b1) seenClr++;
        if (cycles == 6000) begin
            err_count++;
            wrap_up();
        end
    end

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic int armv();
        return ctrl[0] ? 5'h01 : 5'h1e;
    endfunction

    function automatic bit cond(int s, int c);
        bit v;
        v = (s == 3) ? (ev[3] & orig) : ev[s];
        if (pb[s] != 0) v ^= c[pb[s]];
        return v;
    endfunction

    task automatic hit(int s);
        if (s == 5) clrCnt++;
        else if ((((armv() & ~stat) >> s) & 1) != 0) stat |= 1 << s;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s exp %h seen %h", n, exp, seen);
        end
    endtask

    // ----------------------------------------
    // Stimulus helpers
    // ----------------------------------------
    task automatic wreg(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        host.wr(a, d, resp);
        check("bresp", 32'(resp), 32'(er));
    endtask

    task automatic rreg(logic [7:0] a, logic [31:0] exp, logic [1:0] er);
        host.rd(a, rd, resp);
        check("rresp", 32'(resp), 32'(er));
        if (er == RESP_OKAY) check("rdata", rd, exp);
    endtask

    task automatic cstat();
        rreg(8'h1c, stat, RESP_OKAY);
        check("irq", 32'(irq), 32'((stat & mask & armv()) != 0));
    endtask

    task automatic lev(int s, logic v);
        bit o;
        int irqOld;
        o = cond(s, ctrl);
        irqOld = (stat & mask & armv()) != 0;
        @(posedge ref_clk);
        ev[s] <= v;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        check("irq sync", 32'(irq), 32'(irqOld));
        repeat (5) @(posedge ref_clk);
        if (!o && cond(s, ctrl)) hit(s);
    endtask

    task automatic setctrl(int c);
        bit o[6];
        for (int s = 0; s < 6; s++) o[s] = cond(s, ctrl);
        wreg(8'h18, c, RESP_OKAY);
        ctrl = c;
        repeat (8) @(posedge ref_clk);
        for (int s = 0; s < 6; s++) if (!o[s] && cond(s, ctrl)) hit(s);
    endtask

    task automatic clr(int v);
        wreg(8'h1c, v, RESP_OKAY);
        stat &= ~v;
    endtask

    task automatic setmask(int v);
        wreg(8'h08, v, RESP_OKAY);
        mask = v & 5'h1f;
    endtask

    task automatic wrap_up();
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        rreg(8'h08, 0, RESP_OKAY);
        rreg(8'h18, 0, RESP_OKAY);
        cstat();
        cv <= 24'(xs());
        lv <= 24'(xs());
        @(posedge ref_clk);
        rreg(8'h00, 32'(cv), RESP_OKAY);
        rreg(8'h04, 32'(lv), RESP_OKAY);
        wreg(8'h00, xs(), RESP_SLVERR);
        wreg(8'h04, xs(), RESP_SLVERR);
        rreg(8'h00, 32'(cv), RESP_OKAY);
        wreg(8'h0c, xs(), RESP_OKAY);
        rreg(8'h0c, 0, RESP_OKAY);
        wreg(8'h20, xs(), RESP_DECERR);
        rreg(8'h20, 0, RESP_DECERR);
        setmask(xs());
        rreg(8'h08, mask, RESP_OKAY);
        setmask(5'h1f);
        lev(3, 1'b1);
        lev(3, 1'b0);
        cstat();
        orig <= 1'b1;
        for (int s = 0; s < 6; s++) begin
            lev(s, 1'b1);
            lev(s, 1'b0);
        end
        cstat();
        check("clr pulses", seenClr, clrCnt);
        lev(1, 1'b1);
        lev(1, 1'b0);
        cstat();
        setmask(0);
        cstat();
        setmask(5'h1f);
        clr(5'h1e);
        cstat();
        lev(2, 1'b1);
        lev(2, 1'b0);
        cstat();
        clr(5'h1f);
        setctrl(1);
        for (int s = 0; s < 5; s++) begin
            lev(s, 1'b1);
            lev(s, 1'b0);
        end
        cstat();
        clr(5'h1f);
        setctrl(0);
        setctrl(16'h7000);
        cstat();
        lev(1, 1'b1);
        lev(5, 1'b1);
        clr(5'h1f);
        lev(1, 1'b0);
        lev(5, 1'b0);
        cstat();
        check("clr pulses", seenClr, clrCnt);
        rreg(8'h18, 16'h7000, RESP_OKAY);
        wrap_up();
    end
endmodule
